// ==== rtl/srb_pkg.sv ====
// package: commands, bank states, timing counts for the refresh/bank state block
package srb_pkg;
	localparam int BANKS       = 4;
	localparam int ROW_W       = 13;
	localparam int ADDR_W      = 13;
	localparam int CNT_W       = 8;
	localparam int AP_BIT      = 10;
	localparam int CLK_PERIOD_PS = 20000;
	// timing intervals in nanoseconds, then the minimum self refresh exit count in cycles
	localparam int PRECHARGE_PERIOD_NS       = 18;
	localparam int ROW_TO_COLUMN_DELAY_NS    = 18;
	localparam int REFRESH_CYCLE_TIME_NS     = 66;
	localparam int MODE_LOAD_DELAY_NS        = 12;
	localparam int SELF_REFRESH_EXIT_TIME_NS = 67;
	localparam int SELF_REFRESH_INTERVAL_NS  = 7813;
	localparam int MIN_SREF_EXIT_CYCLES      = 2;
	// cycle counts, rounded up, at least one cycle
	function automatic int srb_cyc(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int RP_CYC   = srb_cyc(PRECHARGE_PERIOD_NS);
	localparam int RCD_CYC  = srb_cyc(ROW_TO_COLUMN_DELAY_NS);
	localparam int RFC_CYC  = srb_cyc(REFRESH_CYCLE_TIME_NS);
	localparam int MRD_CYC  = srb_cyc(MODE_LOAD_DELAY_NS);
	localparam int XSR_RAW  = srb_cyc(SELF_REFRESH_EXIT_TIME_NS);
	localparam int XSR_CYC  = (XSR_RAW < MIN_SREF_EXIT_CYCLES) ?
		MIN_SREF_EXIT_CYCLES : XSR_RAW;
	localparam int SREF_INT_CYC = srb_cyc(SELF_REFRESH_INTERVAL_NS);

	typedef enum logic [3:0] {
		CMD_INHIBIT, CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE,
		CMD_BURST_STOP, CMD_PRECHARGE, CMD_REFRESH, CMD_MODE_LOAD
	} srb_cmd_t;

	typedef enum logic [2:0] {
		BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE,
		BK_READ_AP, BK_WRITE_AP, BK_PRECHARGING
	} srb_bank_state_t;

	typedef enum logic [2:0] {
		DV_NORMAL, DV_REFRESHING, DV_MODE_LOAD, DV_PRECHARGE_ALL,
		DV_SELF_REFRESH, DV_SREF_EXIT
	} srb_dev_state_t;

	// command pins as sampled on the rising edge, chip select and strobes active low
	typedef struct packed {
		logic              chip_sel_n;
		logic              row_strobe_n;
		logic              col_strobe_n;
		logic              write_strobe_n;
		logic              clk_en;
		logic              bank_select_hi;
		logic              bank_select_lo;
		logic [ADDR_W-1:0] addr;
	} srb_pins_t;

	// decoded command for one bank
	typedef struct packed {
		logic act;
		logic rd;
		logic wr;
		logic pre;
		logic ap;
		logic stop;
	} srb_bank_cmd_t;
endpackage

// ==== rtl/srb_bank.sv ====
// one bank's command-state machine with its busy-time counter
`timescale 1ns/1ps
module srb_bank (
	input  wire logic                    ref_clk_i,
	input  wire logic                    rst_i,
	input  wire srb_pkg::srb_bank_cmd_t  cmd_i,
	input  wire logic                    force_idle_i,
	output srb_pkg::srb_bank_state_t     state_o
);
	import srb_pkg::*;

	srb_bank_state_t  state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;

	always_comb begin
		state_d = state_q;
		cnt_d   = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
		case (state_q)
			BK_IDLE: begin
				// RULE12: idle activate
				if (cmd_i.act) begin
					state_d = BK_ACTIVATING;
					cnt_d   = CNT_W'(RCD_CYC - 1);
				end
				// RULE13: idle precharge is nop
			end
			// RULE18: timed busy states
			BK_ACTIVATING: begin
				if (cnt_q == '0)
					state_d = BK_ACTIVE;
			end
			BK_PRECHARGING, BK_READ_AP, BK_WRITE_AP: begin
				// RULE19: auto precharge to idle
				if (cnt_q == '0)
					state_d = BK_IDLE;
			end
			BK_ACTIVE, BK_READ, BK_WRITE: begin
				// RULE14: read, write, precharge
				// RULE15: precharge cuts burst
				if (cmd_i.pre) begin
					state_d = BK_PRECHARGING;
					cnt_d   = CNT_W'(RP_CYC - 1);
				end else if (cmd_i.rd || cmd_i.wr) begin
					if (cmd_i.ap) begin
						state_d = cmd_i.rd ? BK_READ_AP : BK_WRITE_AP;
						cnt_d   = CNT_W'(RP_CYC - 1);
					end else begin
						state_d = cmd_i.rd ? BK_READ : BK_WRITE;
					end
				// RULE16: burst stop
				end else if (cmd_i.stop && state_q != BK_ACTIVE) begin
					state_d = BK_ACTIVE;
				end
			end
			default: state_d = BK_IDLE;
		endcase
		// RULE24: end of precharge-all forces banks idle
		if (force_idle_i) begin
			state_d = BK_IDLE;
			cnt_d   = '0;
		end
	end

	// RULE25: counter timing
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_q <= BK_IDLE;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	assign state_o = state_q;
endmodule // srb_bank

// ==== rtl/srb_top.sv ====
// refresh and per-bank command-state logic of a synchronous dram
// Contract
// RULE1: controller issues one refresh command per refresh needed.
// RULE2: controller precharges all banks, waits precharge period, before refresh.
// RULE3: refresh row comes from internal counter; address pins ignored.
// RULE4: controller gives 8192 refreshes per 64 ms (16 ms automotive).
// RULE5: distributed refresh every 7.813 us (1.953 us automotive) suffices.
// RULE6: or 8192 refreshes back to back at refresh cycle time.
// RULE7: refresh with clock enable low enters self refresh; inputs ignored.
// RULE8: in self refresh device times and performs its own refreshes.
// RULE9: controller stays in self refresh at least row active minimum.
// RULE10: exit: stable clock, raise clock enable, nops for exit time.
// RULE11: after exit, refreshes resume every 7.81 us or less.
// RULE12: idle bank accepts activate, refresh, mode load, precharge.
// RULE13: precharge to idle bank leaves it idle, acts as nop.
// RULE14: active bank accepts read, write, precharge, with or without ap.
// RULE15: precharge truncates open burst; new read or write restarts.
// RULE16: burst stop ends most recent burst in any bank.
// RULE17: controller sends only nop to a bank in timed states.
// RULE18: precharge and activate states end after their periods.
// RULE19: auto precharge access busy for precharge period, then idle.
// RULE20: controller nops during refresh, mode load, precharge-all times.
// RULE21: refresh and mode load only when every bank idle.
// RULE22: commands act only with clock enable high now and before.
// RULE23: command decode from chip select and three strobes.
// RULE24: address bit ten on precharge selects all banks.
// RULE25: busy states timed by counters from rounded-up periods.
`timescale 1ns/1ps
module srb_top (
	input  wire logic                          ref_clk_i,
	input  wire logic                          rst_i,
	input  wire srb_pkg::srb_pins_t            pins_i,
	output srb_pkg::srb_dev_state_t            dev_state_o,
	output logic [srb_pkg::BANKS*3-1:0]        bank_states_o,
	output logic [srb_pkg::ROW_W-1:0]          refresh_row_o,
	output logic                               refresh_pulse_o,
	output logic                               all_idle_o
);
	import srb_pkg::*;

	srb_cmd_t        cmd;
	srb_dev_state_t  dev_q, dev_d;
	logic            cke_prev_q;
	logic [CNT_W-1:0] dcnt_q, dcnt_d;
	logic [15:0]      osc_q, osc_d;
	logic [ROW_W-1:0] row_q, row_d;
	logic            pulse_d, pulse_q;
	logic [1:0]      bank_idx;
	logic [1:0]      last_bank_q, last_bank_d;
	logic            accept;
	logic            all_idle;
	logic            pre_all;
	logic            force_idle;
	srb_bank_state_t bst [BANKS];
	srb_bank_cmd_t   bcmd [BANKS];
	logic [BANKS*3-1:0] bst_flat;

	// RULE23: command decode
	always_comb begin
		if (pins_i.chip_sel_n)
			cmd = CMD_INHIBIT;
		else begin
			case ({pins_i.row_strobe_n, pins_i.col_strobe_n,
				pins_i.write_strobe_n})
				3'h7: cmd = CMD_NOP;
				3'h3: cmd = CMD_ACTIVATE;
				3'h5: cmd = CMD_READ;
				3'h4: cmd = CMD_WRITE;
				3'h6: cmd = CMD_BURST_STOP;
				3'h2: cmd = CMD_PRECHARGE;
				3'h1: cmd = CMD_REFRESH;
				3'h0: cmd = CMD_MODE_LOAD;
				default: cmd = CMD_NOP;
			endcase
		end
	end

	assign bank_idx = {pins_i.bank_select_hi, pins_i.bank_select_lo};

	// RULE22: both clock-enable edges high, normal state
	assign accept = cke_prev_q && pins_i.clk_en && dev_q == DV_NORMAL;
	assign pre_all = accept && cmd == CMD_PRECHARGE && pins_i.addr[AP_BIT];
	assign force_idle = dev_q == DV_PRECHARGE_ALL && dcnt_q == '0;

	always_comb begin
		all_idle = 1'b1;
		for (int b = 0; b < BANKS; b++) begin
			if (bst[b] != BK_IDLE)
				all_idle = 1'b0;
		end
	end

	// RULE16: track most recent burst bank
	always_comb begin
		last_bank_d = last_bank_q;
		if (accept && (cmd == CMD_READ || cmd == CMD_WRITE))
			last_bank_d = bank_idx;
	end

	genvar g;
	generate
		for (g = 0; g < BANKS; g++) begin : g_bank
			logic sel;
			assign sel = accept && bank_idx == 2'(g);
			assign bcmd[g].act  = sel && cmd == CMD_ACTIVATE;
			assign bcmd[g].rd   = sel && cmd == CMD_READ;
			assign bcmd[g].wr   = sel && cmd == CMD_WRITE;
			// RULE24: single or all banks
			assign bcmd[g].pre  = accept && cmd == CMD_PRECHARGE &&
				(pins_i.addr[AP_BIT] || bank_idx == 2'(g));
			assign bcmd[g].ap   = pins_i.addr[AP_BIT];
			assign bcmd[g].stop = accept && cmd == CMD_BURST_STOP &&
				last_bank_q == 2'(g);
			srb_bank u_bank (
				.ref_clk_i    (ref_clk_i),
				.rst_i        (rst_i),
				.cmd_i        (bcmd[g]),
				.force_idle_i (force_idle),
				.state_o      (bst[g])
			);
			assign bst_flat[g*3 +: 3] = bst[g];
		end
	endgenerate

	// device-wide state: refresh, mode load, precharge all, self refresh
	always_comb begin
		dev_d   = dev_q;
		dcnt_d  = (dcnt_q != '0) ? dcnt_q - 1'b1 : dcnt_q;
		osc_d   = osc_q;
		row_d   = row_q;
		pulse_d = 1'b0;
		case (dev_q)
			DV_NORMAL: begin
				if (cke_prev_q && cmd == CMD_REFRESH && all_idle) begin
					// RULE3: row from internal counter
					row_d   = row_q + 1'b1;
					pulse_d = 1'b1;
					if (pins_i.clk_en) begin
						dev_d  = DV_REFRESHING;
						dcnt_d = CNT_W'(RFC_CYC - 1);
					end else begin
						// RULE7: self refresh entry
						dev_d = DV_SELF_REFRESH;
						osc_d = 16'(SREF_INT_CYC - 1);
					end
				end else if (accept && cmd == CMD_MODE_LOAD && all_idle) begin
					dev_d  = DV_MODE_LOAD;
					dcnt_d = CNT_W'(MRD_CYC - 1);
				end else if (pre_all) begin
					dev_d  = DV_PRECHARGE_ALL;
					dcnt_d = CNT_W'(RP_CYC - 1);
				end
			end
			DV_REFRESHING, DV_MODE_LOAD, DV_PRECHARGE_ALL, DV_SREF_EXIT: begin
				if (dcnt_q == '0)
					dev_d = DV_NORMAL;
			end
			DV_SELF_REFRESH: begin
				// RULE8: internal refresh timer
				if (osc_q == '0) begin
					osc_d   = 16'(SREF_INT_CYC - 1);
					row_d   = row_q + 1'b1;
					pulse_d = 1'b1;
				end else begin
					osc_d = osc_q - 1'b1;
				end
				// RULE10: exit waits exit time
				if (pins_i.clk_en) begin
					dev_d  = DV_SREF_EXIT;
					dcnt_d = CNT_W'(XSR_CYC - 1);
				end
			end
			default: dev_d = DV_NORMAL;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			dev_q       <= DV_NORMAL;
			dcnt_q      <= '0;
			osc_q       <= '0;
			row_q       <= '0;
			pulse_q     <= 1'b0;
			cke_prev_q  <= 1'b0;
			last_bank_q <= '0;
		end else begin
			dev_q       <= dev_d;
			dcnt_q      <= dcnt_d;
			osc_q       <= osc_d;
			row_q       <= row_d;
			pulse_q     <= pulse_d;
			cke_prev_q  <= pins_i.clk_en;
			last_bank_q <= last_bank_d;
		end
	end

	// registered status outputs
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			bank_states_o <= '0;
			all_idle_o    <= 1'b1;
		end else begin
			bank_states_o <= bst_flat;
			all_idle_o    <= all_idle;
		end
	end

	assign dev_state_o     = dev_q;
	assign refresh_row_o   = row_q;
	assign refresh_pulse_o = pulse_q;
endmodule // srb_top

// ==== test/srb_props.sv ====
// checker: timing relations at the refresh and bank state ports
`timescale 1ns/1ps
module srb_props (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire srb_pkg::srb_pins_t pins_i,
	input wire srb_pkg::srb_dev_state_t dev_state_o,
	input wire logic [srb_pkg::BANKS*3-1:0] bank_states_o,
	input wire logic [srb_pkg::ROW_W-1:0] refresh_row_o,
	input wire logic refresh_pulse_o,
	input wire logic all_idle_o
);
	import srb_pkg::*;
	logic [3:0] c;
	logic cke_q, quiet_q;
	assign c = {pins_i.chip_sel_n, pins_i.row_strobe_n,
		pins_i.col_strobe_n, pins_i.write_strobe_n};
	// last clock enable and whether the last command was idle
	always_ff @(posedge ref_clk_i) begin
		cke_q <= !rst_i && pins_i.clk_en;
		quiet_q <= c[3] || c == 4'h7;
	end
	wire ok = cke_q && quiet_q && dev_state_o == DV_NORMAL
		&& bank_states_o == '0 && all_idle_o;
	wire b0 = pins_i.clk_en && !pins_i.bank_select_hi
		&& !pins_i.bank_select_lo;
	wire in_sr = dev_state_o == DV_SELF_REFRESH;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_refresh;
		dev_state_o == DV_REFRESHING [*4] ##1 dev_state_o == DV_NORMAL;
	endsequence
	sequence s_activate;
		bank_states_o[2:0] == BK_ACTIVATING
		##1 bank_states_o[2:0] == BK_ACTIVE;
	endsequence
	a_refresh_enter: assert property (
		ok && c == 4'h1 && pins_i.clk_en |=> refresh_pulse_o ##0 s_refresh)
		else $error("refresh entry");
	a_row_step: assert property (
		refresh_pulse_o |-> refresh_row_o == $past(refresh_row_o) + 1'b1)
		else $error("refresh row step");
	a_sref_entry: assert property (
		ok && c == 4'h1 && !pins_i.clk_en |=> in_sr)
		else $error("self refresh entry");
	a_sref_ignore: assert property (
		in_sr && !pins_i.clk_en |=> in_sr && $stable(bank_states_o))
		else $error("self refresh left");
	a_sref_timer: assert property (
		refresh_pulse_o && in_sr |-> ##[1:400] (refresh_pulse_o || !in_sr))
		else $error("no internal refresh");
	a_sref_exit: assert property (
		in_sr && pins_i.clk_en |=> dev_state_o != DV_NORMAL [*2]
		##[1:8] dev_state_o == DV_NORMAL)
		else $error("self refresh exit");
	a_act_bank0: assert property (
		ok && c == 4'h3 && b0 |-> ##2 s_activate)
		else $error("activate timing");
	a_pre_idle: assert property (
		ok && c == 4'h2 && b0 && !pins_i.addr[AP_BIT]
		|-> ##1 bank_states_o[2:0] == BK_IDLE [*3])
		else $error("idle bank changed");
endmodule // srb_props
bind srb_top srb_props srb_props_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.pins_i(pins_i), .dev_state_o(dev_state_o),
	.bank_states_o(bank_states_o), .refresh_row_o(refresh_row_o),
	.refresh_pulse_o(refresh_pulse_o), .all_idle_o(all_idle_o));

// ==== test/srb_ctrl.sv ====
// controller model: drives the command pins off the falling edge
`timescale 1ns/1ps
module srb_ctrl (
	input wire logic ref_clk_i,
	output srb_pkg::srb_pins_t pins_o
);
	import srb_pkg::*;
	initial pins_o = {4'h7, 1'b1, 15'h0};
	// pin order cs ras cas we
	task automatic drive(input logic [3:0] c, input logic [1:0] b,
		input logic ap, input logic ck, input logic [12:0] ad);
		@(negedge ref_clk_i);
		ad[AP_BIT] = ap;
		pins_o = {c, ck, b, ad};
	endtask
endmodule // srb_ctrl

// ==== test/testbench.sv ====
// testbench: refresh and bank sequences against a reference model
`timescale 1ns/1ps
`define CK(a, e) begin comparisons++; if ((a) !== (e)) begin \
	failures++; $display("[FAIL] %0t mismatch", $time); end end
module testbench;
	import srb_pkg::*;
	localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4;
	localparam logic [3:0] BST = 4'h6, PRE = 4'h2, REF = 4'h1, MRS = 4'h0;
	localparam logic [3:0] INH = 4'h8;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	srb_pins_t pins;
	srb_dev_state_t dev;
	logic [BANKS*3-1:0] bst;
	logic [ROW_W-1:0] row, r0;
	logic pulse, idle;
	int failures = 0, comparisons = 0, seed = 32'hf78c;
	srb_bank_state_t st[BANKS];
	always #10 ref_clk_i = !ref_clk_i;
	srb_ctrl srb_ctrl_i (.ref_clk_i(ref_clk_i), .pins_o(pins));
	srb_top srb_top_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.pins_i(pins), .dev_state_o(dev), .bank_states_o(bst),
		.refresh_row_o(row), .refresh_pulse_o(pulse), .all_idle_o(idle));
	task automatic op(input logic [3:0] c, input int b, input logic ap,
		input logic ck, input int n);
		srb_ctrl_i.drive(c, 2'(b), ap, ck, 13'($random(seed)));
		repeat (n)
			srb_ctrl_i.drive(NOP, 2'h0, 1'b0, ck, 13'($random(seed)));
	endtask
	task automatic chk();
		logic all;
		all = 1'b1;
		for (int b = 0; b < BANKS; b++) begin
			`CK(bst[3*b+:3], st[b])
			all &= st[b] == BK_IDLE;
		end
		`CK(idle, all)
		`CK(dev, DV_NORMAL)
	endtask
	task automatic report_and_stop();
		if (failures == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		st = '{default: BK_IDLE};
		repeat (5) @(negedge ref_clk_i);
		rst_i = 1'b0;
		op(NOP, 0, 0, 1, 2);
		chk();
		`CK(row, 13'h0)
		op(PRE, 0, 0, 1, 4);
		chk();
		for (int b = 0; b < BANKS; b++) begin
			op(ACT, b, 0, 1, 0);
			st[b] = BK_ACTIVE;
		end
		op(NOP, 0, 0, 1, 3);
		chk();
		op(RD, 0, 0, 1, 1);
		op(WR, 1, 0, 1, 1);
		op(BST, 3, 0, 1, 1);
		op(PRE, 0, 0, 1, 1);
		op(RD, 2, 1, 1, 1);
		op(WR, 3, 1, 1, 4);
		st = '{BK_IDLE, BK_ACTIVE, BK_IDLE, BK_IDLE};
		chk();
		op(RD, 1, 0, 1, 1);
		op(WR, 1, 0, 1, 3);
		st[1] = BK_WRITE;
		chk();
		op(PRE, 0, 1, 1, 1);
		`CK(dev, DV_PRECHARGE_ALL)
		op(NOP, 0, 0, 1, 3);
		st[1] = BK_IDLE;
		chk();
		r0 = row;
		op(REF, 0, 0, 1, 6);
		`CK(row, r0 + 13'h1)
		op(MRS, 0, 0, 1, 3);
		chk();
		op(ACT, 0, 0, 1, 3);
		r0 = row;
		op(REF, 0, 0, 1, 4);
		`CK(row, r0)
		op(PRE, 0, 0, 1, 3);
		r0 = row;
		op(REF, 0, 0, 0, 0);
		repeat (850)
			srb_ctrl_i.drive(4'($random(seed)), 2'($random(seed)),
				1'b0, 1'b0, 13'($random(seed)));
		`CK(dev, DV_SELF_REFRESH)
		`CK(row, r0 + 13'h3)
		op(NOP, 0, 0, 1, 8);
		chk();
		op(ACT, 2, 0, 1, 4);
		st[2] = BK_ACTIVE;
		chk();
		op(PRE, 0, 1, 1, 2);
		st[2] = BK_IDLE;
		r0 = row;
		op(REF, 0, 0, 1, 0);
		repeat (RFC_CYC)
			srb_ctrl_i.drive(INH, 2'h0, 1'b0, 1'b1, 13'($random(seed)));
		// back to back at cycle time
		op(REF, 0, 0, 1, 0);
		op(NOP, 0, 0, 1, 0);
		`CK(pulse, 1'b1)
		op(NOP, 0, 0, 1, RFC_CYC + 1);
		`CK(pulse, 1'b0)
		`CK(row, r0 + 13'h2)
		chk();
		report_and_stop();
	end
	initial begin
		#100us;
		failures++;
		report_and_stop();
	end
endmodule // testbench
